/* File: hdl/pem_pkg.sv */
// Package for the program event monitor: constants, register map and carriers
// Overview of operation
// (RULE_01) Pending event interruption precedes I/O, timer and repressible machine check.
// (RULE_02) Pending event interruption is taken before the stop state is entered.
// (RULE_03) Fetch event on supervisor call interrupts right after the supervisor-call swap.
// (RULE_04) Event decision uses control values in force before the instruction.
// (RULE_05) Event swap immediately follows a concurrent program interruption swap.
// (RULE_06) Branch event address is the branch or execute instruction; state word points next.
// (RULE_07) Inside an interruptible instruction, event address equals saved instruction address.
// (RULE_08) Monitored range runs from start register up to end register inclusive.
// (RULE_09) Range wraps past the top address back to zero when start exceeds end.
// (RULE_10) Equal start and end monitor exactly one byte.
// (RULE_11) Range comparison uses all 24 address bits.
// (RULE_12) Successful branch with mask bit 0 and state-word mask sets code bit 0.
// (RULE_13) Only branch instructions that really transfer control count as successful.
// (RULE_14) Fetch of first byte in range with mask bit 1 sets code bit 1.
// (RULE_15) Executed subject or execute instruction in range gives a fetch event.
// (RULE_16) Processor store into range with mask bit 2 sets code bit 2.
// (RULE_17) Any operand part in range counts; protection indicating stores count too.
// (RULE_18) Storing an unchanged value still counts as an alteration.
// (RULE_19) Implicit interruption, I/O and logout stores are not monitored.
// (RULE_20) Channel stores and storage key changes raise no alteration.
// (RULE_21) Zero-mask char store, zero-length long move no alteration; two always alter.
// (RULE_22) State load, supervisor or monitor call disabling events still interrupt.
// (RULE_23) One state-word bit is the master mask; zero blocks all events.
// (RULE_24) Swap stores old word at 80h, new from 88h, writes event info area.
// (RULE_25) Masked events are discarded, never held pending.
package pem_pkg;
    localparam int          AW              = 24;
    localparam logic [23:0] OLD_SW_LOC      = 24'h000080;
    localparam logic [23:0] NEW_SW_LOC      = 24'h000088;
    localparam logic [23:0] EVT_INFO_LOC    = 24'h0001F0;
    localparam int          BIT_BRANCH      = 0;
    localparam int          BIT_FETCH       = 1;
    localparam int          BIT_STORE       = 2;
    localparam logic [11:0] REG_MASK_OFS    = 12'h000;
    localparam logic [11:0] REG_START_OFS   = 12'h004;
    localparam logic [11:0] REG_END_OFS     = 12'h008;
    localparam logic [11:0] REG_STATUS_OFS  = 12'h00C;
    localparam logic [11:0] REG_ADDR_OFS    = 12'h010;
    localparam logic [2:0]  MASK_RST        = 3'h0;
    localparam logic [23:0] ADDR_RST        = 24'h000000;

    typedef enum logic [1:0] {
        SWAP_NONE = 2'h0,
        SWAP_PROG = 2'h1,
        SWAP_EVT  = 2'h3,
        SWAP_ASYN = 2'h2
    } pem_seq_t;

    // One completed instruction from the pipeline
    typedef struct packed {
        logic        valid;
        logic        br_taken;
        logic        is_branch_op;
        logic [23:0] instr_addr;
        logic        via_execute;
        logic [23:0] exec_addr;
        logic        store_valid;
        logic [23:0] store_lo;
        logic [23:0] store_hi;
        logic        store_implicit;
        logic        store_channel;
        logic        store_key_only;
        logic        store_empty;
        logic        store_forced;
        logic        sw_event_mask;
        logic        interruptible;
        logic        prog_intr;
        logic        svc_intr;
        logic        async_pend;
        logic        stop_req;
        logic [23:0] next_addr;
    } pem_instr_t;

    // Event interruption request to the sequencer
    typedef struct packed {
        logic        req;
        logic [2:0]  code;
        logic [23:0] addr;
        logic [23:0] old_sw_loc;
        logic [23:0] new_sw_loc;
        logic [23:0] info_loc;
        logic        after_prog;
        logic        hold_async;
        logic        hold_stop;
    } pem_intr_t;

    typedef struct packed {
        logic [2:0]  mask;
        logic [23:0] start_a;
        logic [23:0] end_a;
        logic [2:0]  last_code;
        logic [23:0] last_addr;
        logic [31:0] prdata;
        logic        pready;
        pem_intr_t   intr;
        pem_seq_t    seq;
    } pem_state_t;
endpackage

/* File: hdl/pem_monitor.sv */
// Program event monitor: range checks, event code, swap ordering, APB control registers
`timescale 1ns/1ps
module pem_monitor #(
    parameter int ADDR_W = 24
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire pem_pkg::pem_instr_t instr,
    input  wire logic                swap_done,
    output pem_pkg::pem_intr_t       intr
);
    import pem_pkg::*;

    // Elaboration check: the range logic serves the full address width only
    if (ADDR_W != AW) begin : g_width_check
        $error("ADDR_W must be 24");
    end

    pem_state_t s_r;
    pem_state_t s_nxt;

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] st, input logic [23:0] en);
        if (st <= en) begin
            in_range = (a >= st) && (a <= en);  // RULE_08 RULE_10 RULE_11
        end else begin
            in_range = (a >= st) || (a <= en);  // RULE_09
        end
    endfunction

    // Operand span [lo,hi] touches range when either end lies in it or it covers the start
    function automatic logic span_hit(input logic [23:0] lo, input logic [23:0] hi,
                                      input logic [23:0] st, input logic [23:0] en);
        span_hit = in_range(lo, st, en) || in_range(hi, st, en) || in_range(st, lo, hi);
    endfunction

    logic       acc;
    logic       wr;
    logic       br_ev;
    logic       fe_ev;
    logic       st_ev;
    logic [2:0] code;

    always_comb begin
        acc = psel && penable;
        wr  = acc && pwrite;
        // Decisions use registered controls, i.e. values before this instruction's writes
        br_ev = instr.valid && instr.br_taken && instr.is_branch_op
                && s_r.mask[BIT_BRANCH];  // RULE_04 RULE_12 RULE_13
        fe_ev = instr.valid && s_r.mask[BIT_FETCH]
                && (in_range(instr.instr_addr, s_r.start_a, s_r.end_a)
                    || (instr.via_execute && in_range(instr.exec_addr, s_r.start_a, s_r.end_a)));  // RULE_14 RULE_15
        st_ev = instr.valid && instr.store_valid && s_r.mask[BIT_STORE]
                && !instr.store_implicit && !instr.store_channel && !instr.store_key_only  // RULE_19 RULE_20
                && (instr.store_forced || !instr.store_empty)  // RULE_21
                && span_hit(instr.store_lo, instr.store_hi, s_r.start_a, s_r.end_a);  // RULE_16 RULE_17 RULE_18
        code = 3'h0;
        code[BIT_BRANCH] = br_ev;
        code[BIT_FETCH]  = fe_ev;
        code[BIT_STORE]  = st_ev;
        if (!instr.sw_event_mask) begin
            code = 3'h0;  // RULE_23 RULE_25
        end

        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        if (psel && !penable) begin
            s_nxt.pready = 1'b1;
            if (paddr == REG_MASK_OFS) begin
                s_nxt.prdata = {29'h0, s_r.mask};
            end else if (paddr == REG_START_OFS) begin
                s_nxt.prdata = {8'h0, s_r.start_a};
            end else if (paddr == REG_END_OFS) begin
                s_nxt.prdata = {8'h0, s_r.end_a};
            end else if (paddr == REG_STATUS_OFS) begin
                s_nxt.prdata = {29'h0, s_r.last_code};
            end else if (paddr == REG_ADDR_OFS) begin
                s_nxt.prdata = {8'h0, s_r.last_addr};
            end else begin
                s_nxt.prdata = 32'h0;
            end
        end
        if (wr && s_r.pready) begin
            if (paddr == REG_MASK_OFS) begin
                s_nxt.mask = pwdata[2:0];
            end else if (paddr == REG_START_OFS) begin
                s_nxt.start_a = pwdata[23:0];
            end else if (paddr == REG_END_OFS) begin
                s_nxt.end_a = pwdata[23:0];
            end
        end

        if (s_r.intr.req && swap_done) begin
            s_nxt.intr.req        = 1'b0;
            s_nxt.intr.hold_async = 1'b0;
            s_nxt.intr.hold_stop  = 1'b0;
            s_nxt.seq             = s_r.intr.hold_async ? SWAP_ASYN : SWAP_NONE;
        end
        // New events are only taken at instruction end; no pending hold otherwise
        if (instr.valid && code != 3'h0) begin
            s_nxt.intr.req        = 1'b1;
            s_nxt.intr.code       = code;  // RULE_12 RULE_14 RULE_16
            s_nxt.intr.addr       = instr.via_execute ? instr.exec_addr : instr.instr_addr;  // RULE_06
            if (instr.interruptible) begin
                s_nxt.intr.addr   = instr.next_addr;  // RULE_07
            end
            s_nxt.intr.old_sw_loc = OLD_SW_LOC;  // RULE_24
            s_nxt.intr.new_sw_loc = NEW_SW_LOC;
            s_nxt.intr.info_loc   = EVT_INFO_LOC;
            s_nxt.intr.after_prog = instr.prog_intr || instr.svc_intr;  // RULE_03 RULE_05 RULE_22
            s_nxt.intr.hold_async = instr.async_pend;  // RULE_01
            s_nxt.intr.hold_stop  = instr.stop_req;  // RULE_02
            s_nxt.seq             = (instr.prog_intr || instr.svc_intr) ? SWAP_PROG : SWAP_EVT;
            s_nxt.last_code       = code;
            s_nxt.last_addr       = s_nxt.intr.addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{mask: MASK_RST, start_a: ADDR_RST, end_a: ADDR_RST, last_code: 3'h0,
                     last_addr: ADDR_RST, prdata: 32'h0, pready: 1'b0, intr: '0, seq: SWAP_NONE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = 1'b0;
    assign intr    = s_r.intr;

    // Request waiting for the sequencer, with no new event arriving
    sequence s_evt_open;
        intr.req && !swap_done && !(instr.valid && code != 3'h0);
    endsequence

    // Request still up with its code and address unchanged
    sequence s_evt_stands;
        intr.req && $stable(intr.code) && $stable(intr.addr);
    endsequence

    a_branch_code: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_12
        instr.valid && instr.sw_event_mask && instr.br_taken && instr.is_branch_op && s_r.mask[BIT_BRANCH]
        |=> intr.req && intr.code[BIT_BRANCH]) else $error("branch event not raised");
    a_master_mask: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_23
        instr.valid && !instr.sw_event_mask && !intr.req |=> !intr.req)
        else $error("event raised while masked");
    a_single_byte: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_10
        instr.valid && instr.sw_event_mask && s_r.mask[BIT_FETCH] && s_r.start_a == s_r.end_a
        && instr.instr_addr == s_r.start_a |=> intr.code[BIT_FETCH]) else $error("single byte missed");
    a_wrap_fetch: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_09
        instr.valid && instr.sw_event_mask && s_r.mask[BIT_FETCH] && s_r.start_a > s_r.end_a
        && instr.instr_addr == 24'h000000 |=> intr.code[BIT_FETCH]) else $error("wrap range missed");
    a_implicit_store: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_19
        instr.valid && instr.store_implicit && !instr.br_taken && !s_r.mask[BIT_FETCH] && !intr.req
        |=> !intr.req) else $error("implicit store monitored");
    a_exec_addr: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_06
        instr.valid && instr.via_execute && !instr.interruptible && code != 3'h0
        |=> intr.addr == $past(instr.exec_addr)) else $error("execute address wrong");
    a_intr_addr: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_07
        instr.valid && instr.interruptible && code != 3'h0
        |=> intr.addr == $past(instr.next_addr)) else $error("interruptible address wrong");
    a_async_after: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_01
        instr.valid && instr.async_pend && code != 3'h0 |=> intr.req && intr.hold_async)
        else $error("async not held behind event");
    a_swap_locs: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_24
        intr.req |-> intr.old_sw_loc == OLD_SW_LOC && intr.new_sw_loc == NEW_SW_LOC)
        else $error("swap locations wrong");
    a_req_stands: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_01
        s_evt_open |=> s_evt_stands) else $error("event request dropped before swap");
    a_req_clear: assert property (@(posedge pclk) disable iff (!presetn)  // RULE_25
        intr.req && swap_done && !(instr.valid && code != 3'h0) |=> !intr.req)
        else $error("event request kept after swap");
endmodule

/* File: tb/pem_seq_model.sv */
// Sequencer model: answers an event request with a swap-done pulse
`timescale 1ns/1ps
module pem_seq_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       req,
    input  wire logic [3:0] dly,
    output logic            swap_done
);
    logic [3:0] cnt_r;
    // Pulse once per request after dly cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 4'h0;
            swap_done <= 1'b0;
        end else begin
            swap_done <= req && !swap_done && (cnt_r >= dly);
            cnt_r     <= (req && !swap_done) ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: tb/program_event_monitor_bench.sv */
// Bench for the program event monitor
`timescale 1ns/1ps
module program_event_monitor_bench;
    import pem_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        pready, pslverr, swap_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  dly;
    pem_instr_t  instr, b;
    pem_intr_t   intr, got;
    int          error_cnt, checks_done, cyc;

    always #10 pclk = ~pclk;

    pem_monitor u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .instr, .swap_done, .intr);
    pem_seq_model u_seq (.pclk, .presetn, .req(intr.req), .dly, .swap_done);

    task automatic results;
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        chk("pready wait", n, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [2:0] m, input logic [23:0] s, input logic [23:0] e);
        apb(1, REG_MASK_OFS, {29'h0, m});
        apb(1, REG_START_OFS, {8'h0, s});
        apb(1, REG_END_OFS, {8'h0, e});
    endtask

    task automatic base(input logic [23:0] a);
        b = '0;
        b.valid = 1'b1;
        b.sw_event_mask = 1'b1;
        b.instr_addr = a;
    endtask

    task automatic evt(input pem_instr_t i, input logic [2:0] c);
        int n;
        n = 0;
        @(posedge pclk);
        instr <= i;
        @(posedge pclk);
        instr <= '0;
        #1;
        got = intr;
        chk("req", intr.req, |c);
        if (|c)
            chk("code", intr.code, c);
        while (intr.req !== 1'b0 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("req clr", intr.req, 0);
    endtask

    task automatic fc(input logic [23:0] s, input logic [23:0] e, input logic [23:0] a, input logic h);
        cfg(3'h2, s, e);
        base(a);
        evt(b, h ? 3'h2 : 3'h0);
    endtask

    task automatic t_regs;
        apb(0, REG_MASK_OFS, 0);
        chk("mask rst", rd, {29'h0, MASK_RST});
        apb(0, REG_ADDR_OFS, 0);
        chk("addr rst", rd, {8'h0, ADDR_RST});
        apb(1, REG_START_OFS, 32'h00ABCDEF);
        apb(0, REG_START_OFS, 0);
        chk("start", rd, 32'h00ABCDEF);
        apb(0, 12'h020, 0);
        chk("unmapped", rd, 0);
        chk("slverr", pslverr, 0);
    endtask

    task automatic t_branch;
        cfg(3'h1, 24'h0, 24'h0);
        base(24'h001234);
        b.br_taken = 1'b1;
        b.is_branch_op = 1'b1;
        evt(b, 3'h1);
        chk("br addr", got.addr, 32'h001234);
        chk("no prog", got.after_prog, 0);
        chk("no async", got.hold_async, 0);
        chk("no stop", got.hold_stop, 0);
        b.br_taken = 1'b0;
        evt(b, 3'h0);
        b.br_taken = 1'b1;
        b.sw_event_mask = 1'b0;
        evt(b, 3'h0);
        b.sw_event_mask = 1'b1;
        cfg(3'h6, 24'h0, 24'h0);
        evt(b, 3'h0);
        cfg(3'h1, 24'h0, 24'h0);
        b.br_taken = 1'b0;
        evt(b, 3'h0);
    endtask

    task automatic t_fetch;
        fc(24'h000100, 24'h0001FF, 24'h0001FF, 1);
        fc(24'h000100, 24'h0001FF, 24'h000200, 0);
        fc(24'h000100, 24'h0001FF, 24'h0000FF, 0);
        fc(24'h000100, 24'h0001FF, 24'h010100, 0);
        fc(24'hFFFFF0, 24'h000010, 24'h000005, 1);
        fc(24'hFFFFF0, 24'h000010, 24'hFFFFFF, 1);
        fc(24'hFFFFF0, 24'h000010, 24'h000011, 0);
        fc(24'hFFFFF0, 24'h000010, 24'h000000, 1);
        fc(24'h000345, 24'h000345, 24'h000345, 1);
        fc(24'h000345, 24'h000345, 24'h000346, 0);
        b.via_execute = 1'b1;
        b.exec_addr = 24'h000345;
        evt(b, 3'h2);
    endtask

    task automatic t_store;
        cfg(3'h4, 24'h000100, 24'h0001FF);
        base(24'h800000);
        b.store_valid = 1'b1;
        b.store_lo = 24'h0000F0;
        b.store_hi = 24'h000103;
        evt(b, 3'h4);
        for (int k = 0; k < 5; k++) begin
            {b.store_implicit, b.store_channel, b.store_key_only, b.store_empty, b.store_forced} =
                (k == 4) ? 5'h03 : (5'h10 >> k);
            evt(b, (k == 4) ? 3'h4 : 3'h0);
        end
    endtask

    task automatic t_order;
        dly = 4'h9;
        cfg(3'h2, 24'h000100, 24'h0001FF);
        base(24'h000150);
        b.next_addr = 24'h000154;
        b.prog_intr = 1'b1;
        evt(b, 3'h2);
        chk("after prog", got.after_prog, 1);
        chk("old loc", got.old_sw_loc, {8'h0, OLD_SW_LOC});
        chk("new loc", got.new_sw_loc, {8'h0, NEW_SW_LOC});
        chk("info loc", got.info_loc, {8'h0, EVT_INFO_LOC});
        b.prog_intr = 1'b0;
        b.svc_intr = 1'b1;
        evt(b, 3'h2);
        chk("after svc", got.after_prog, 1);
        b.svc_intr = 1'b0;
        b.interruptible = 1'b1;
        b.async_pend = 1'b1;
        evt(b, 3'h2);
        chk("hold async", got.hold_async, 1);
        chk("intr addr", got.addr, 32'h000154);
        b.async_pend = 1'b0;
        b.stop_req = 1'b1;
        evt(b, 3'h2);
        chk("hold stop", got.hold_stop, 1);
        apb(0, REG_STATUS_OFS, 0);
        chk("last code", rd, 32'h00000002);
        apb(0, REG_ADDR_OFS, 0);
        chk("last addr", rd, 32'h00000154);
        apb(0, REG_END_OFS, 0);
        chk("end", rd, 32'h000001FF);
        apb(0, REG_MASK_OFS, 0);
        chk("mask", rd, 32'h00000002);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        instr = '0;
        dly = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_branch();
        t_fetch();
        t_store();
        t_order();
        results();
    end
endmodule
